/* rtl/scb_map.vh */
/*
 Constants for the system control block handler: byte offsets of words inside the
 control block, command and status field positions, unit codes.
 Assumes the block sits behind a simple word-wide memory master port.
*/
`ifndef SCB_MAP_VH
`define SCB_MAP_VH
`define SCB_OFF_CMD 32'h00000000
`define SCB_OFF_PTR 32'h00000004
`define SCB_OFF_CNT0 32'h00000008
`define SCB_OFF_THR 32'h00000020
`define SCB_ACK_LSB 28
`define SCB_RESET_BIT 23
`define SCB_CUC_LSB 24
`define SCB_RUC_LSB 20
`define SCB_EVT_LSB 12
`define SCB_CUS_LSB 8
`define SCB_RUS_LSB 4
`define SCB_THR_BIT 3
`define SCB_CUS_IDLE 3'h0
`define SCB_CUS_SUSP 3'h1
`define SCB_CUS_ACT 3'h2
`define SCB_RUS_IDLE 4'h0
`define SCB_RUS_SUSP 4'h1
`define SCB_RUS_NORES 4'h2
`define SCB_RUS_READY 4'h4
`define SCB_RUS_NORBD 4'hA
`define SCB_RUS_NOMORE 4'hC
`define SCB_CNT_CRC 3'h0
`define SCB_CNT_ALN 3'h1
`define SCB_CNT_RSC 3'h2
`define SCB_CNT_OVR 3'h3
`define SCB_CNT_CDT 3'h4
`define SCB_CNT_SHRT 3'h5
`define SCB_MIN_COLL_BYTES 16'h0040
`define SCB_INT_GAP 4'h4
`endif

/* rtl/scb_ctrl.v */
/*
 System control block handler: fetches and executes control commands on
 channel attention, writes the status word, keeps statistics counters.
 Assumes a single-outstanding memory port with a ready handshake.
*/
`include "scb_map.vh"
module scb_ctrl #(
   parameter AW = 32
) (
   input wire CLK_SYS_IN,
   input wire RESETN_IN,
   input wire CHANNEL_ATTENTION_IN,
   input wire COMPAT_MODE_IN,
   input wire LINEAR_MODE_IN,
   input wire MONITOR_MODE_IN,
   input wire [AW-1:0] SCB_BASE_IN,
   output reg MEM_REQ_OUT,
   output reg MEM_WE_OUT,
   output reg [AW-1:0] MEM_ADDR_OUT,
   output reg [31:0] MEM_WDATA_OUT,
   output reg MEM_LOCK_OUT,
   input wire MEM_READY_IN,
   input wire [31:0] MEM_RDATA_IN,
   input wire CMD_DONE_EVT_IN,
   input wire FRAME_RX_EVT_IN,
   input wire CU_IDLE_EVT_IN,
   input wire CU_SUSP_EVT_IN,
   input wire RU_NORES_EVT_IN,
   input wire [1:0] RU_NORES_KIND_IN,
   input wire FRAME_END_IN,
   input wire FRAME_CRC_ERR_IN,
   input wire FRAME_MISALIGNED_IN,
   input wire FRAME_SHORT_IN,
   input wire FRAME_DISCARDED_IN,
   input wire FRAME_BUS_LOST_IN,
   input wire FRAME_COLLISION_IN,
   input wire FRAME_IN_PREAMBLE_IN,
   input wire [15:0] FRAME_BYTES_IN,
   input wire THR_TERMINAL_IN,
   input wire THR_RUNNING_IN,
   output reg [2:0] CU_CMD_OUT,
   output reg [2:0] RU_CMD_OUT,
   output reg UNIT_CMD_STB_OUT,
   output reg [31:0] CMD_LIST_PTR_OUT,
   output reg [31:0] RX_AREA_PTR_OUT,
   output reg [31:0] THR_VALUES_OUT,
   output reg THR_LOAD_OUT,
   output reg [2:0] CMD_UNIT_STATE_OUT,
   output reg [3:0] RX_UNIT_STATE_OUT,
   output reg INT_OUT
);
   localparam S_IDLE = 9'h001;
   localparam S_RDCMD = 9'h002;
   localparam S_RDPTR = 9'h004;
   localparam S_RDTHR = 9'h008;
   localparam S_CLR = 9'h010;
   localparam S_STAT = 9'h020;
   localparam S_CRD = 9'h040;
   localparam S_CWR = 9'h080;
   localparam S_EXEC = 9'h100;

   reg [8:0] state_r;
   reg ca_d_r;
   reg ca_latch_r;
   reg [31:0] cmd_r;
   reg [3:0] evt_r;
   reg [5:0] pend_r;
   reg [2:0] cnt_sel_r;
   reg thr_loaded_r;
   reg thr_staged_r;
   reg ovr_hold_r;
   reg soft_rst_r;
   reg stat_dirty_r;
   reg [3:0] gap_r;
   reg int_want_r;
   reg [3:0] new_evt;
   reg [5:0] frame_hits;
   reg [2:0] next_cnt;
   reg [2:0] cus_nxt;
   reg [3:0] rus_nxt;
   reg thr_nxt;
   reg rst_pend_r;
   integer i;
   wire rst = ~RESETN_IN | soft_rst_r;
   wire [2:0] cmd_unit_control = cmd_r[`SCB_CUC_LSB+2:`SCB_CUC_LSB];
   wire [2:0] rx_unit_control = cmd_r[`SCB_RUC_LSB+2:`SCB_RUC_LSB];
   wire [15:0] status_word = {evt_r, 1'b0, CMD_UNIT_STATE_OUT, RX_UNIT_STATE_OUT,
                              thr_loaded_r & ~COMPAT_MODE_IN, 3'h0};

   always @* begin
      new_evt = {CMD_DONE_EVT_IN, FRAME_RX_EVT_IN, CU_IDLE_EVT_IN | CU_SUSP_EVT_IN, RU_NORES_EVT_IN};
      frame_hits = 6'h00;
      if (FRAME_END_IN && !FRAME_IN_PREAMBLE_IN) begin
         frame_hits[`SCB_CNT_CRC] = FRAME_CRC_ERR_IN & ~FRAME_MISALIGNED_IN;
         frame_hits[`SCB_CNT_ALN] = FRAME_CRC_ERR_IN & FRAME_MISALIGNED_IN;
         frame_hits[`SCB_CNT_RSC] = MONITOR_MODE_IN |
            (FRAME_DISCARDED_IN && (RX_UNIT_STATE_OUT == `SCB_RUS_NORES ||
             RX_UNIT_STATE_OUT == `SCB_RUS_NORBD));
         frame_hits[`SCB_CNT_OVR] = FRAME_BUS_LOST_IN & ~ovr_hold_r;
         frame_hits[`SCB_CNT_CDT] = FRAME_COLLISION_IN && FRAME_BYTES_IN >= `SCB_MIN_COLL_BYTES;
         frame_hits[`SCB_CNT_SHRT] = FRAME_SHORT_IN |
            (FRAME_COLLISION_IN && FRAME_BYTES_IN < `SCB_MIN_COLL_BYTES);
      end
      next_cnt = 3'h0;
      for (i = 5; i >= 0; i = i - 1) begin
         if (pend_r[i]) begin
            next_cnt = i[2:0];
         end
      end
      case (cmd_unit_control)
         3'h1, 3'h2: cus_nxt = `SCB_CUS_ACT;
         3'h4: cus_nxt = `SCB_CUS_IDLE;
         default: cus_nxt = CMD_UNIT_STATE_OUT;
      endcase
      case (rx_unit_control)
         3'h1: rus_nxt = `SCB_RUS_READY;
         3'h2: rus_nxt = (RX_UNIT_STATE_OUT == `SCB_RUS_SUSP) ? `SCB_RUS_READY : RX_UNIT_STATE_OUT;
         3'h3: rus_nxt = `SCB_RUS_SUSP;
         3'h4: rus_nxt = `SCB_RUS_IDLE;
         default: rus_nxt = RX_UNIT_STATE_OUT;
      endcase
      // Loaded flag as it will stand
      thr_nxt = thr_loaded_r | (thr_staged_r & (THR_TERMINAL_IN | ~THR_RUNNING_IN));
   end

   always @(posedge CLK_SYS_IN) begin
      if (rst) begin
         state_r <= S_IDLE;
         ca_d_r <= 1'b0;
         ca_latch_r <= 1'b0;
         cmd_r <= 32'h00000000;
         evt_r <= 4'h0;
         pend_r <= 6'h00;
         cnt_sel_r <= 3'h0;
         thr_loaded_r <= 1'b0;
         thr_staged_r <= 1'b0;
         ovr_hold_r <= 1'b0;
         soft_rst_r <= 1'b0;
         rst_pend_r <= 1'b0;
         stat_dirty_r <= 1'b0;
         gap_r <= 4'h0;
         int_want_r <= 1'b0;
         INT_OUT <= 1'b0;
         MEM_REQ_OUT <= 1'b0;
         MEM_WE_OUT <= 1'b0;
         MEM_ADDR_OUT <= {AW{1'b0}};
         MEM_WDATA_OUT <= 32'h00000000;
         MEM_LOCK_OUT <= 1'b0;
         CU_CMD_OUT <= 3'h0;
         RU_CMD_OUT <= 3'h0;
         UNIT_CMD_STB_OUT <= 1'b0;
         CMD_LIST_PTR_OUT <= 32'h00000000;
         RX_AREA_PTR_OUT <= 32'h00000000;
         THR_VALUES_OUT <= 32'h00000000;
         THR_LOAD_OUT <= 1'b0;
         CMD_UNIT_STATE_OUT <= `SCB_CUS_IDLE;
         RX_UNIT_STATE_OUT <= `SCB_RUS_IDLE;
      end else begin
         UNIT_CMD_STB_OUT <= 1'b0;
         THR_LOAD_OUT <= 1'b0;
         ca_d_r <= CHANNEL_ATTENTION_IN;
         if (ca_d_r && !CHANNEL_ATTENTION_IN) begin
            ca_latch_r <= 1'b1;
         end
         pend_r <= pend_r | frame_hits;
         if (FRAME_END_IN) begin
            ovr_hold_r <= FRAME_BUS_LOST_IN;
         end
         if (|new_evt) begin
            evt_r <= evt_r | new_evt;
            stat_dirty_r <= 1'b1;
            if (INT_OUT) begin
               gap_r <= `SCB_INT_GAP;
            end
         end
         if (CU_IDLE_EVT_IN) begin
            CMD_UNIT_STATE_OUT <= `SCB_CUS_IDLE;
         end else if (CU_SUSP_EVT_IN) begin
            CMD_UNIT_STATE_OUT <= `SCB_CUS_SUSP;
         end
         if (RU_NORES_EVT_IN) begin
            if (COMPAT_MODE_IN || RU_NORES_KIND_IN == 2'h0) begin
               RX_UNIT_STATE_OUT <= `SCB_RUS_NORES;
            end else if (RU_NORES_KIND_IN == 2'h1) begin
               RX_UNIT_STATE_OUT <= `SCB_RUS_NORBD;
            end else begin
               RX_UNIT_STATE_OUT <= `SCB_RUS_NOMORE;
            end
         end
         // Staged values land at terminal count, or at once when the timer is not running
         if (thr_staged_r && (THR_TERMINAL_IN || !THR_RUNNING_IN)) begin
            thr_staged_r <= 1'b0;
            thr_loaded_r <= 1'b1;
            THR_LOAD_OUT <= 1'b1;
         end
         if (gap_r != 4'h0) begin
            gap_r <= gap_r - 4'h1;
         end
         INT_OUT <= int_want_r && (|evt_r) && gap_r == 4'h0 && !(|new_evt && INT_OUT);
         case (state_r)
            S_IDLE: begin
               if (ca_latch_r) begin
                  ca_latch_r <= ca_d_r && !CHANNEL_ATTENTION_IN;
                  MEM_REQ_OUT <= 1'b1;
                  MEM_WE_OUT <= 1'b0;
                  MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_CMD;
                  state_r <= S_RDCMD;
               end else if (|pend_r) begin
                  cnt_sel_r <= next_cnt;
                  MEM_LOCK_OUT <= 1'b1;
                  MEM_REQ_OUT <= 1'b1;
                  MEM_WE_OUT <= 1'b0;
                  MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_CNT0 + {next_cnt, 2'b00};
                  state_r <= S_CRD;
               end else if (stat_dirty_r) begin
                  stat_dirty_r <= 1'b0;
                  MEM_REQ_OUT <= 1'b1;
                  MEM_WE_OUT <= 1'b1;
                  MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_CMD;
                  MEM_WDATA_OUT <= {cmd_r[31:16], status_word};
                  state_r <= S_STAT;
               end
            end
            S_RDCMD: begin
               if (MEM_READY_IN) begin
                  cmd_r <= MEM_RDATA_IN;
                  evt_r <= (evt_r & ~MEM_RDATA_IN[31:`SCB_ACK_LSB]) | new_evt;
                  if (MEM_RDATA_IN[`SCB_CUC_LSB+2:`SCB_CUC_LSB] == 3'h1 ||
                      MEM_RDATA_IN[`SCB_RUC_LSB+2:`SCB_RUC_LSB] == 3'h1) begin
                     MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_PTR;
                     state_r <= S_RDPTR;
                  end else if (!COMPAT_MODE_IN && (MEM_RDATA_IN[26:24] == 3'h5 ||
                               MEM_RDATA_IN[26:24] == 3'h6)) begin
                     MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_THR;
                     state_r <= S_RDTHR;
                  end else begin
                     MEM_REQ_OUT <= 1'b0;
                     state_r <= S_EXEC;
                  end
               end
            end
            S_RDPTR: begin
               if (MEM_READY_IN) begin
                  MEM_REQ_OUT <= 1'b0;
                  if (cmd_unit_control == 3'h1) begin
                     CMD_LIST_PTR_OUT <= LINEAR_MODE_IN ? MEM_RDATA_IN : {16'h0000, MEM_RDATA_IN[15:0]};
                  end
                  if (rx_unit_control == 3'h1) begin
                     RX_AREA_PTR_OUT <= LINEAR_MODE_IN ? MEM_RDATA_IN : {16'h0000, MEM_RDATA_IN[31:16]};
                  end
                  state_r <= S_EXEC;
               end
            end
            S_RDTHR: begin
               if (MEM_READY_IN) begin
                  MEM_REQ_OUT <= 1'b0;
                  THR_VALUES_OUT <= MEM_RDATA_IN;
                  if (cmd_unit_control == 3'h6) begin
                     THR_LOAD_OUT <= 1'b1;
                     thr_loaded_r <= 1'b1;
                  end else begin
                     thr_staged_r <= 1'b1;
                  end
                  state_r <= S_EXEC;
               end
            end
            S_EXEC: begin
               // Reset once the clear is written
               if (cmd_r[`SCB_RESET_BIT]) begin
                  rst_pend_r <= 1'b1;
               end
               CU_CMD_OUT <= (cmd_unit_control == 3'h7 || (cmd_unit_control >= 3'h5 && COMPAT_MODE_IN)) ?
                             3'h0 : cmd_unit_control;
               RU_CMD_OUT <= (rx_unit_control >= 3'h5 || (rx_unit_control == 3'h2 && RX_UNIT_STATE_OUT != `SCB_RUS_SUSP)) ? 3'h0 : rx_unit_control;
               UNIT_CMD_STB_OUT <= 1'b1;
               CMD_UNIT_STATE_OUT <= cus_nxt;
               RX_UNIT_STATE_OUT <= rus_nxt;
               MEM_REQ_OUT <= 1'b1;
               MEM_WE_OUT <= 1'b1;
               MEM_ADDR_OUT <= SCB_BASE_IN + `SCB_OFF_CMD;
               MEM_WDATA_OUT <= {16'h0000, evt_r, 1'b0, cus_nxt, rus_nxt,
                                 thr_nxt & ~COMPAT_MODE_IN, 3'h0};
               cmd_r <= 32'h00000000;
               state_r <= S_CLR;
            end
            S_CLR, S_STAT: begin
               if (MEM_READY_IN) begin
                  MEM_REQ_OUT <= 1'b0;
                  MEM_WE_OUT <= 1'b0;
                  int_want_r <= 1'b1;
                  soft_rst_r <= rst_pend_r;
                  state_r <= S_IDLE;
               end
            end
            S_CRD: begin
               if (MEM_READY_IN) begin
                  MEM_WE_OUT <= 1'b1;
                  MEM_WDATA_OUT <= MEM_RDATA_IN + 32'h00000001;
                  state_r <= S_CWR;
               end
            end
            S_CWR: begin
               if (MEM_READY_IN) begin
                  MEM_REQ_OUT <= 1'b0;
                  MEM_WE_OUT <= 1'b0;
                  MEM_LOCK_OUT <= 1'b0;
                  pend_r <= (pend_r & ~(6'h01 << cnt_sel_r)) | frame_hits;
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule // scb_ctrl

/* tb/scb_mem_model.sv */
/* Control block memory on the far side of the memory port.
   Assumes one access at a time; answers after lat_in wait cycles. */
module scb_mem_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] lat_in,
   output logic ready_out,
   output logic [31:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:15];
   logic [3:0] wait_r = 4'h0;
   initial begin
      ready_out = 1'b0;
      rdata_out = 32'h0;
      foreach (mem[i]) mem[i] = 32'h0;
   end
   // Read data only valid with ready
   always @(posedge clk_in) begin
      ready_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ready_out) begin
         wait_r <= wait_r + 4'h1;
         if (wait_r >= lat_in) begin
            wait_r <= 4'h0;
            ready_out <= 1'b1;
            if (we_in)
               mem[addr_in[5:2]] <= wdata_in;
            else
               rdata_out <= mem[addr_in[5:2]];
         end
      end
   end
endmodule // scb_mem_model

/* tb/scb_ctrl_chk.sv */
/* Port checker for the control block handler.
   Bound to every scb_ctrl instance; sees its ports only. */
module scb_ctrl_chk #(
   parameter AW = 32
) (
   input wire CLK_SYS_IN,
   input wire RESETN_IN,
   input wire CHANNEL_ATTENTION_IN,
   input wire COMPAT_MODE_IN,
   input wire [AW-1:0] SCB_BASE_IN,
   input wire MEM_REQ_OUT,
   input wire MEM_WE_OUT,
   input wire [AW-1:0] MEM_ADDR_OUT,
   input wire [31:0] MEM_WDATA_OUT,
   input wire MEM_LOCK_OUT,
   input wire MEM_READY_IN,
   input wire [31:0] MEM_RDATA_IN,
   input wire [2:0] CU_CMD_OUT,
   input wire [2:0] RU_CMD_OUT,
   input wire UNIT_CMD_STB_OUT,
   input wire [2:0] CMD_UNIT_STATE_OUT,
   input wire [3:0] RX_UNIT_STATE_OUT
);
   logic [31:0] cnt_rd_r;
   default clocking @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RESETN_IN);
   always @(posedge CLK_SYS_IN)
      if (MEM_REQ_OUT && MEM_READY_IN && MEM_LOCK_OUT && !MEM_WE_OUT)
         cnt_rd_r <= MEM_RDATA_IN;
   hold_req_a: assert property (
      MEM_REQ_OUT && !MEM_READY_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WDATA_OUT))
      else $error("request changed before ready");
   lock_incr_a: assert property (
      MEM_REQ_OUT && MEM_WE_OUT && MEM_LOCK_OUT |-> MEM_WDATA_OUT == cnt_rd_r + 32'h1)
      else $error("counter not incremented");
   ca_fetch_a: assert property (
      $fell(CHANNEL_ATTENTION_IN) && !MEM_REQ_OUT && !MEM_LOCK_OUT
      |-> ##[1:200] (MEM_REQ_OUT && !MEM_WE_OUT && MEM_ADDR_OUT == SCB_BASE_IN))
      else $error("no command fetch");
   stb_pulse_a: assert property (UNIT_CMD_STB_OUT |=> !UNIT_CMD_STB_OUT)
      else $error("strobe too long");
   cu_state_a: assert property (CMD_UNIT_STATE_OUT <= 3'h2)
      else $error("bad unit state");
   rx_state_a: assert property (
      RX_UNIT_STATE_OUT inside {4'h0, 4'h1, 4'h2, 4'h4, 4'hA, 4'hC})
      else $error("bad receive state");
   cu_refuse_a: assert property (
      UNIT_CMD_STB_OUT |-> CU_CMD_OUT != 3'h7 && !(COMPAT_MODE_IN && CU_CMD_OUT > 3'h4))
      else $error("invalid unit command");
   ru_refuse_a: assert property (UNIT_CMD_STB_OUT |-> RU_CMD_OUT <= 3'h4)
      else $error("invalid receive command");
endmodule // scb_ctrl_chk
bind scb_ctrl scb_ctrl_chk #(.AW(AW)) u_scb_ctrl_chk (
   .CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN), .CHANNEL_ATTENTION_IN(CHANNEL_ATTENTION_IN),
   .COMPAT_MODE_IN(COMPAT_MODE_IN), .SCB_BASE_IN(SCB_BASE_IN), .MEM_REQ_OUT(MEM_REQ_OUT),
   .MEM_WE_OUT(MEM_WE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
   .MEM_LOCK_OUT(MEM_LOCK_OUT), .MEM_READY_IN(MEM_READY_IN), .MEM_RDATA_IN(MEM_RDATA_IN),
   .CU_CMD_OUT(CU_CMD_OUT), .RU_CMD_OUT(RU_CMD_OUT), .UNIT_CMD_STB_OUT(UNIT_CMD_STB_OUT),
   .CMD_UNIT_STATE_OUT(CMD_UNIT_STATE_OUT), .RX_UNIT_STATE_OUT(RX_UNIT_STATE_OUT)
);

/* tb/scb_ctrl_test.sv */
/* Self-checking bench for the control block handler.
   Assumes scb_mem_model as control block memory and the bound checker. */
module scb_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ca = 1'b0;
   logic compat = 1'b0;
   logic linear = 1'b0;
   logic [4:0] evt = 5'h00;
   logic [7:0] frm = 8'h00;
   logic [15:0] nbytes = 16'h0000;
   logic [3:0] lat = 4'h0;
   logic mon = 1'b0;
   logic thr_term = 1'b0;
   logic thr_run = 1'b0;
   logic [1:0] kind = 2'h0;
   logic [2:0] cu_seen, ru_seen;
   logic [31:0] thr_seen;
   wire req, we, lock, ready, stb, thr_load, intr;
   wire [31:0] addr, wdata, rdata, cbl_ptr, rfa_ptr, thr_vals;
   wire [2:0] cu_cmd, ru_cmd, cus;
   wire [3:0] rx_unit_state;
   int miscompares = 0;
   int cmp_count = 0;
   always #2.5 clk = ~clk;
   scb_ctrl u_scb_ctrl (
      .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CHANNEL_ATTENTION_IN(ca), .COMPAT_MODE_IN(compat),
      .LINEAR_MODE_IN(linear), .MONITOR_MODE_IN(mon), .SCB_BASE_IN(32'h00000100),
      .MEM_REQ_OUT(req), .MEM_WE_OUT(we), .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata),
      .MEM_LOCK_OUT(lock), .MEM_READY_IN(ready), .MEM_RDATA_IN(rdata),
      .CMD_DONE_EVT_IN(evt[0]), .FRAME_RX_EVT_IN(evt[1]), .CU_IDLE_EVT_IN(evt[2]),
      .CU_SUSP_EVT_IN(evt[3]), .RU_NORES_EVT_IN(evt[4]), .RU_NORES_KIND_IN(kind),
      .FRAME_END_IN(frm[0]), .FRAME_CRC_ERR_IN(frm[1]), .FRAME_MISALIGNED_IN(frm[2]),
      .FRAME_SHORT_IN(frm[3]), .FRAME_DISCARDED_IN(frm[4]), .FRAME_BUS_LOST_IN(frm[5]),
      .FRAME_COLLISION_IN(frm[6]), .FRAME_IN_PREAMBLE_IN(frm[7]), .FRAME_BYTES_IN(nbytes),
      .THR_TERMINAL_IN(thr_term), .THR_RUNNING_IN(thr_run), .CU_CMD_OUT(cu_cmd), .RU_CMD_OUT(ru_cmd),
      .UNIT_CMD_STB_OUT(stb), .CMD_LIST_PTR_OUT(cbl_ptr), .RX_AREA_PTR_OUT(rfa_ptr),
      .THR_VALUES_OUT(thr_vals), .THR_LOAD_OUT(thr_load), .CMD_UNIT_STATE_OUT(cus),
      .RX_UNIT_STATE_OUT(rx_unit_state), .INT_OUT(intr)
   );
   scb_mem_model u_scb_mem_model (
      .clk_in(clk), .req_in(req), .we_in(we), .addr_in(addr), .wdata_in(wdata),
      .lat_in(lat), .ready_out(ready), .rdata_out(rdata)
   );
   always @(posedge clk) begin
      if (stb) begin
         cu_seen <= cu_cmd;
         ru_seen <= ru_cmd;
      end
      if (thr_load)
         thr_seen <= thr_vals;
   end
   function automatic logic [31:0] mw(input int i);
      return u_scb_mem_model.mem[i];
   endfunction
   task tick;
      @(posedge clk);
      #1;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task host_wr(input int i, input logic [31:0] d);
      do begin
         while (lock || req)
            tick;
         tick;
      end while (lock || req);
      u_scb_mem_model.mem[i] = d;
   endtask
   task run_cmd(input logic [15:0] hi);
      int n;
      n = 0;
      cu_seen = 3'h7;
      ru_seen = 3'h7;
      thr_seen = 32'h0;
      host_wr(0, {hi, 16'h0000} | mw(0) & 32'hFFFF);
      ca = 1'b1;
      tick;
      ca = 1'b0;
      chk(req, 1'b0);
      while (((mw(0) & 32'hFFFF0000) !== 0 || req) && n < 300) begin
         tick;
         n++;
      end
      tick;
      chk(mw(0) & 32'hFFFF0000, 0);
   endtask
   task mem_is(input int i, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      while ((mw(i) & m) !== v && n < 200) begin
         tick;
         n++;
      end
      chk(mw(i) & m, v);
   endtask
   task frame(input logic [7:0] q, input logic [15:0] b);
      frm = q;
      nbytes = b;
      tick;
      frm = 8'h00;
      tick;
   endtask
   task t_cu;
      int k;
      chk({req, intr, cus, rx_unit_state}, 0);
      host_wr(1, 32'hBEEF1234);
      host_wr(8, 32'h00200010);
      for (k = 1; k < 8; k++) begin
         run_cmd({5'h00, k[2:0], 8'h00});
         chk(cu_seen, (k == 7) ? 0 : k);
         if (k == 1)
            chk(cus, 3'h2);
         if (k == 5 || k == 6)
            chk(thr_seen | mw(0) & 32'h8, 32'h00200018);
      end
      chk(cbl_ptr, 32'h00001234);
      compat = 1'b1;
      for (k = 5; k < 7; k++) begin
         run_cmd({5'h00, k[2:0], 8'h00});
         chk({cu_seen, thr_seen}, 0);
      end
      compat = 1'b0;
   endtask
   task t_ru;
      logic [2:0] rq [0:7] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
      logic [2:0] ex [0:7] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0};
      int k;
      host_wr(1, 32'hBEEF5678);
      for (k = 0; k < 8; k++) begin
         run_cmd({9'h000, rq[k], 4'h0});
         chk(ru_seen, ex[k]);
         if (k == 0 || k == 2)
            chk(rx_unit_state, (k == 0) ? 4 : 1);
      end
      chk({rfa_ptr, cbl_ptr}, 64'h0000BEEF_00001234);
   endtask
   task t_lin;
      linear = 1'b1;
      host_wr(1, 32'hCAFE0042);
      run_cmd(16'h0110);
      chk(cbl_ptr & rfa_ptr, 32'hCAFE0042);
      chk(cbl_ptr | rfa_ptr, 32'hCAFE0042);
      linear = 1'b0;
   endtask
   task t_evt;
      int n;
      logic low;
      n = 0;
      low = 1'b0;
      evt = 5'h01;
      tick;
      evt = 5'h00;
      mem_is(0, 32'h8000, 32'h8000);
      while (intr !== 1'b1 && n < 50) begin
         tick;
         n++;
      end
      evt = 5'h02;
      tick;
      evt = 5'h00;
      repeat (10) begin
         low = low | !intr;
         tick;
      end
      chk({low, intr}, 2'b11);
      evt = 5'h14;
      tick;
      evt = 5'h00;
      mem_is(0, 32'h7000, 32'h7000);
      chk({cus, rx_unit_state}, 7'h02);
      run_cmd(16'h8000);
      chk({intr, mw(0) & 32'hF000}, 33'h100007000);
      run_cmd(16'h7000);
      chk({intr, mw(0) & 32'hF000}, 0);
   endtask
   task t_cnt;
      int k;
      lat = 4'h3;
      for (k = 3; k < 8; k++)
         host_wr(k, 32'h0);
      host_wr(2, ALL);
      frame(8'h03, 16'h0080);
      mem_is(2, ALL, 0);
      frame(8'h07, 16'h0080);
      mem_is(3, ALL, 1);
      frame(8'h43, 16'h0040);
      mem_is(6, ALL, 1);
      mem_is(2, ALL, 1);
      frame(8'h41, 16'h003F);
      mem_is(7, ALL, 1);
      frame(8'hC1, 16'h0000);
      frame(8'h11, 16'h0080);
      mem_is(4, ALL, 1);
      chk(mw(6) + mw(7), 2);
      frame(8'h21, 16'h0080);
      mem_is(5, ALL, 1);
      lat = 4'h0;
   endtask
   task t_mode;
      kind = 2'h1;
      evt = 5'h10;
      tick;
      chk(rx_unit_state, 4'hA);
      kind = 2'h2;
      tick;
      chk(rx_unit_state, 4'hC);
      compat = 1'b1;
      kind = 2'h1;
      tick;
      chk(rx_unit_state, 4'h2);
      evt = 5'h00;
      compat = 1'b0;
      kind = 2'h0;
      mon = 1'b1;
      frame(8'h01, 16'h0080);
      mon = 1'b0;
      mem_is(4, ALL, 2);
      thr_run = 1'b1;
      host_wr(8, 32'h00300020);
      run_cmd(16'h0500);
      chk(thr_seen, 0);
      thr_term = 1'b1;
      tick;
      thr_term = 1'b0;
      thr_run = 1'b0;
      tick;
      chk(thr_seen, 32'h00300020);
   endtask
   task t_rst;
      run_cmd(16'h0110);
      run_cmd(16'h0080);
      chk({req, intr, cus, rx_unit_state}, 0);
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      tick;
      t_cu;
      t_ru;
      t_lin;
      t_evt;
      t_cnt;
      t_mode;
      t_rst;
      summarize;
   end
   initial begin
      #250000;
      miscompares++;
      summarize;
   end
endmodule // scb_ctrl_test
